// *** design/ctrl_byte_reg.sv ***
// Purpose: One regulator control byte with reset, NVM default load and bus write.
// Assumes: Reset beats NVM load, NVM load beats a bus write in the same cycle.
// Notes:   Reserved bits are forced to zero by the write mask.
module ctrl_byte_reg #(
    parameter logic [7:0] RESET_VALUE = regbank_pkg::RST_CTRL,
    parameter logic [7:0] WRITE_MASK  = regbank_pkg::MASK_REG1_CTRL
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       nvm_load,
    input  wire logic [7:0] nvm_value,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] value
);

    typedef struct packed {
        logic [7:0] data;
    } ctrl_state_t;

    ctrl_state_t state_reg;
    ctrl_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        if (nvm_load)
        begin
            state_next.data = nvm_value & WRITE_MASK;
        end
        else if (wr_en)
        begin
            state_next.data = wr_data & WRITE_MASK;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg.data <= RESET_VALUE & WRITE_MASK;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign value = state_reg.data;

endmodule

// *** design/regbank_pkg.sv ***
// Purpose: Shared constants for the regulator control register bank.
// Assumes: Byte-wide registers at fixed byte offsets of the serial interface.
// Notes:   Field positions and reset values are defined here; the assertions and the bench repeat some of them as literals.
package regbank_pkg;

    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;

    localparam logic [7:0]  OFS_REVISION    = 8'h03;
    localparam logic [7:0]  OFS_REG1_CTRL   = 8'h04;
    localparam logic [7:0]  OFS_REG1_CONF   = 8'h05;
    localparam logic [7:0]  OFS_REG2_CTRL   = 8'h06;

    localparam logic [7:0]  RST_REVISION    = 8'h00;
    localparam logic [7:0]  RST_CTRL        = 8'h22;
    localparam logic [7:0]  RST_CONF        = 8'h22;
    localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;

    // Writable bits; reserved bits hold zero and read as zero.
    localparam logic [7:0]  MASK_REG1_CTRL  = 8'hBF;
    localparam logic [7:0]  MASK_REG2_CTRL  = 8'hBB;
    localparam logic [7:0]  MASK_CONF       = 8'h3F;

    localparam int          BIT_RESIDUAL    = 7;
    localparam int          BIT_PULLDOWN    = 5;
    localparam int          BIT_MONITOR     = 4;
    localparam int          BIT_VSEL        = 3;
    localparam int          BIT_MULTIPHASE  = 2;
    localparam int          BIT_FORCE_PWM   = 1;
    localparam int          BIT_ENABLE      = 0;

    localparam int          ILIM_MSB        = 5;
    localparam int          ILIM_LSB        = 3;
    localparam int          SLEW_MSB        = 2;
    localparam int          SLEW_LSB        = 0;

    // Current limit codes: 2.5 A, 3.5 A, 4.5 A, 6.5 A, 7.5 A; 000, 001 and 101 are reserved.
    localparam logic [2:0]  ILIM_2A5        = 3'h2;
    localparam logic [2:0]  ILIM_3A5        = 3'h3;
    localparam logic [2:0]  ILIM_4A5        = 3'h4;
    localparam logic [2:0]  ILIM_GAP        = 3'h5;
    localparam logic [2:0]  ILIM_6A5        = 3'h6;
    localparam logic [2:0]  ILIM_7A5        = 3'h7;

    // Slew codes in mV/us: 33, 20, 10, 5.0, 2.5, 1.3, 0.63, 0.31.
    localparam logic [2:0]  SLEW_33         = 3'h0;
    localparam logic [2:0]  SLEW_2P5        = 3'h4;
    localparam logic [2:0]  SLEW_0P31       = 3'h7;

endpackage

// *** design/regulator_control_register_bank.sv ***
// Purpose: Register bank for the revision byte and the first two regulator channels.
// Assumes: The serial interface decoder drives a one-cycle write or read strobe on clk.
// Notes:   Read data appears one cycle after the read strobe; unmapped reads give zero.
module regulator_control_register_bank #(
    parameter logic [2:0] ILIM_MAX_CODE = regbank_pkg::ILIM_7A5
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       nvm_load,
    input  wire logic [7:0] nvm_revision,
    input  wire logic [7:0] nvm_reg1_ctrl,
    input  wire logic [7:0] nvm_reg1_conf,
    input  wire logic [7:0] nvm_reg2_ctrl,
    input  wire logic [7:0] bus_addr,
    input  wire logic       bus_wr,
    input  wire logic [7:0] bus_wdata,
    input  wire logic       bus_rd,
    output logic      [7:0] bus_rdata,
    output logic            bus_rvalid,
    output logic      [7:0] nvm_revision_field,
    output logic            reg1_residual_check_en,
    output logic            reg1_pulldown_en,
    output logic            reg1_monitor_en,
    output logic            reg1_voltage_select,
    output logic            reg1_force_multiphase,
    output logic            reg1_force_pwm,
    output logic            reg1_enable,
    output logic      [2:0] reg1_current_limit,
    output logic      [2:0] reg1_slew_select,
    output logic            reg2_residual_check_en,
    output logic            reg2_pulldown_en,
    output logic            reg2_monitor_en,
    output logic            reg2_voltage_select,
    output logic            reg2_force_pwm,
    output logic            reg2_enable
);

    if (ILIM_MAX_CODE < regbank_pkg::ILIM_2A5 || ILIM_MAX_CODE == regbank_pkg::ILIM_GAP)
    begin : g_bad_ilim
        $error("ILIM_MAX_CODE must be a valid current limit code");
    end

    typedef struct packed {
        logic [7:0] revision;
        logic [7:0] conf;
        logic [7:0] rdata;
        logic       rvalid;
    } bank_state_t;

    bank_state_t state_reg;
    bank_state_t state_next;
    logic [7:0]  ctrl_value [2];

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
        return addr == offset;
    endfunction

    // Reserved codes never reach the analog side; the ceiling caps each new legal code, but not the kept old code or the reset code 4.
    function automatic logic [2:0] ilim_filter(input logic [2:0] code, input logic [2:0] old);
        logic [2:0] result;
        result = old;
        if (code >= regbank_pkg::ILIM_2A5 && code != regbank_pkg::ILIM_GAP)
        begin
            result = (code > ILIM_MAX_CODE) ? ILIM_MAX_CODE : code;
        end
        return result;
    endfunction

    function automatic logic [7:0] conf_filter(input logic [7:0] data, input logic [7:0] old);
        logic [7:0] result;
        result = data & regbank_pkg::MASK_CONF;
        result[regbank_pkg::ILIM_MSB:regbank_pkg::ILIM_LSB] =
            ilim_filter(data[regbank_pkg::ILIM_MSB:regbank_pkg::ILIM_LSB],
                        old[regbank_pkg::ILIM_MSB:regbank_pkg::ILIM_LSB]);
        return result;
    endfunction

    for (genvar g = 0; g < 2; g++)
    begin : g_ctrl
        localparam logic [7:0] OFS  = (g == 0) ? regbank_pkg::OFS_REG1_CTRL
                                               : regbank_pkg::OFS_REG2_CTRL;
        localparam logic [7:0] MASK = (g == 0) ? regbank_pkg::MASK_REG1_CTRL
                                               : regbank_pkg::MASK_REG2_CTRL;
        ctrl_byte_reg #(
            .RESET_VALUE (regbank_pkg::RST_CTRL),
            .WRITE_MASK  (MASK)
        ) u_ctrl (
            .clk       (clk),
            .sys_rst   (sys_rst),
            .nvm_load  (nvm_load),
            .nvm_value ((g == 0) ? nvm_reg1_ctrl : nvm_reg2_ctrl),
            .wr_en     (bus_wr && hit(bus_addr, OFS)),
            .wr_data   (bus_wdata),
            .value     (ctrl_value[g])
        );
    end

    always_comb
    begin
        state_next        = state_reg;
        state_next.rvalid = bus_rd;
        if (nvm_load)
        begin
            state_next.revision = nvm_revision;
            state_next.conf     = conf_filter(nvm_reg1_conf, regbank_pkg::RST_CONF);
        end
        else if (bus_wr && hit(bus_addr, regbank_pkg::OFS_REG1_CONF))
        begin
            // No enable check here: a new limit applies while running.
            state_next.conf = conf_filter(bus_wdata, state_reg.conf);
        end
        if (bus_rd)
        begin
            if (hit(bus_addr, regbank_pkg::OFS_REVISION))
            begin
                state_next.rdata = state_reg.revision;
            end
            else if (hit(bus_addr, regbank_pkg::OFS_REG1_CTRL))
            begin
                state_next.rdata = ctrl_value[0];
            end
            else if (hit(bus_addr, regbank_pkg::OFS_REG1_CONF))
            begin
                state_next.rdata = state_reg.conf;
            end
            else if (hit(bus_addr, regbank_pkg::OFS_REG2_CTRL))
            begin
                state_next.rdata = ctrl_value[1];
            end
            else
            begin
                state_next.rdata = regbank_pkg::UNMAPPED_DATA;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg.revision <= regbank_pkg::RST_REVISION;
            state_reg.conf     <= regbank_pkg::RST_CONF;
            state_reg.rdata    <= regbank_pkg::UNMAPPED_DATA;
            state_reg.rvalid   <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign bus_rdata              = state_reg.rdata;
    assign bus_rvalid             = state_reg.rvalid;
    assign nvm_revision_field     = state_reg.revision;
    assign reg1_residual_check_en = ctrl_value[0][regbank_pkg::BIT_RESIDUAL];
    assign reg1_pulldown_en       = ctrl_value[0][regbank_pkg::BIT_PULLDOWN];
    assign reg1_monitor_en        = ctrl_value[0][regbank_pkg::BIT_MONITOR];
    assign reg1_voltage_select    = ctrl_value[0][regbank_pkg::BIT_VSEL];
    assign reg1_force_multiphase  = ctrl_value[0][regbank_pkg::BIT_MULTIPHASE];
    assign reg1_force_pwm         = ctrl_value[0][regbank_pkg::BIT_FORCE_PWM];
    assign reg1_enable            = ctrl_value[0][regbank_pkg::BIT_ENABLE];
    assign reg1_current_limit     = state_reg.conf[regbank_pkg::ILIM_MSB:regbank_pkg::ILIM_LSB];
    assign reg1_slew_select       = state_reg.conf[regbank_pkg::SLEW_MSB:regbank_pkg::SLEW_LSB];
    assign reg2_residual_check_en = ctrl_value[1][regbank_pkg::BIT_RESIDUAL];
    assign reg2_pulldown_en       = ctrl_value[1][regbank_pkg::BIT_PULLDOWN];
    assign reg2_monitor_en        = ctrl_value[1][regbank_pkg::BIT_MONITOR];
    assign reg2_voltage_select    = ctrl_value[1][regbank_pkg::BIT_VSEL];
    assign reg2_force_pwm         = ctrl_value[1][regbank_pkg::BIT_FORCE_PWM];
    assign reg2_enable            = ctrl_value[1][regbank_pkg::BIT_ENABLE];

    logic wr_idle;
    assign wr_idle = bus_wr && !nvm_load;

    property p_revision_locked;
        @(posedge clk) disable iff (sys_rst)
        !nvm_load |=> $stable(nvm_revision_field);
    endproperty
    a_revision_locked: assert property (p_revision_locked)
        else $error("Revision byte changed without an NVM load.");

    property p_reset_defaults;
        @(posedge clk)
        sys_rst |=> (ctrl_value[0] == 8'h22 && ctrl_value[1] == 8'h22
                     && state_reg.conf == 8'h22 && !bus_rvalid);
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("Registers did not take their reset values.");

    property p_nvm_default;
        @(posedge clk) disable iff (sys_rst)
        nvm_load |=> ctrl_value[0] == ($past(nvm_reg1_ctrl) & 8'hBF)
                     && nvm_revision_field == $past(nvm_revision);
    endproperty
    a_nvm_default: assert property (p_nvm_default)
        else $error("NVM defaults were not loaded.");

    property p_ctrl1_write;
        @(posedge clk) disable iff (sys_rst)
        wr_idle && bus_addr == 8'h04 |=>
            {reg1_residual_check_en, reg1_pulldown_en, reg1_monitor_en, reg1_voltage_select,
             reg1_force_multiphase, reg1_force_pwm, reg1_enable}
            == {$past(bus_wdata[7]), $past(bus_wdata[5:0])};
    endproperty
    a_ctrl1_write: assert property (p_ctrl1_write)
        else $error("Regulator one control write did not land on its outputs.");

    property p_ctrl2_reserved;
        @(posedge clk) disable iff (sys_rst)
        wr_idle && bus_addr == 8'h06 |=> ctrl_value[1][2] == 1'b0 && ctrl_value[1][6] == 1'b0
            && reg2_enable == $past(bus_wdata[0]) && reg2_force_pwm == $past(bus_wdata[1]);
    endproperty
    a_ctrl2_reserved: assert property (p_ctrl2_reserved)
        else $error("Regulator two reserved bit was stored.");

    property p_ilim_legal;
        @(posedge clk) disable iff (sys_rst)
        ##1 (reg1_current_limit >= 3'h2 && reg1_current_limit != 3'h5
             && reg1_current_limit <= ILIM_MAX_CODE && state_reg.conf[7:6] == 2'h0);
    endproperty
    a_ilim_legal: assert property (p_ilim_legal)
        else $error("Current limit holds a reserved or excessive code.");

    property p_ilim_live;
        @(posedge clk) disable iff (sys_rst)
        wr_idle && bus_addr == 8'h05 && reg1_enable && bus_wdata[5:3] == 3'h3 |=>
            reg1_current_limit == 3'h3 && reg1_slew_select == $past(bus_wdata[2:0]);
    endproperty
    a_ilim_live: assert property (p_ilim_live)
        else $error("Settings write did not take effect while running.");

    property p_read_back;
        @(posedge clk) disable iff (sys_rst)
        bus_rd && !bus_wr && !nvm_load && bus_addr == 8'h03 ##1 !nvm_load
            |-> bus_rvalid && bus_rdata == nvm_revision_field;
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("Revision read returned the wrong value.");

    property p_unmapped;
        @(posedge clk) disable iff (sys_rst)
        bus_rd && bus_addr > 8'h06 |=> bus_rvalid && bus_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("Unmapped read did not return zero.");

endmodule

// *** sim/test_regulator_control_register_bank.sv ***
// Purpose: Self-checking bench for the regulator control register bank.
// Assumes: Same-clock strobes from the serial interface decoder; limit ceiling lowered to code 6.
// Notes:   Field outputs are packed back into bytes so one compare covers a register.
module test_regulator_control_register_bank;
    timeunit 1ns;
    timeprecision 1ps;

    // A ceiling below the top code lets the clamp be seen at all.
    localparam logic [2:0] MAX_LIM = 3'h6;

    logic       clk;
    logic       sys_rst;
    logic       nvm_load;
    logic [7:0] nvm_revision;
    logic [7:0] nvm_reg1_ctrl;
    logic [7:0] nvm_reg1_conf;
    logic [7:0] nvm_reg2_ctrl;
    logic [7:0] bus_addr;
    logic       bus_wr;
    logic [7:0] bus_wdata;
    logic       bus_rd;
    logic [7:0] bus_rdata;
    logic       bus_rvalid;
    logic [7:0] nvm_revision_field;
    logic       r1_rv, r1_pd, r1_mon, r1_vs, r1_mp, r1_fp, r1_en;
    logic [2:0] reg1_current_limit;
    logic [2:0] reg1_slew_select;
    logic       r2_rv, r2_pd, r2_mon, r2_vs, r2_fp, r2_en;
    logic [7:0] ctrl1;
    logic [7:0] conf1;
    logic [7:0] ctrl2;
    int         bad_count;
    int         comparisons;

    assign ctrl1 = {r1_rv, 1'b0, r1_pd, r1_mon, r1_vs, r1_mp, r1_fp, r1_en};
    assign ctrl2 = {r2_rv, 1'b0, r2_pd, r2_mon, r2_vs, 1'b0, r2_fp, r2_en};
    assign conf1 = {2'b00, reg1_current_limit, reg1_slew_select};

    regulator_control_register_bank #(.ILIM_MAX_CODE(MAX_LIM)) u_regulator_control_register_bank (
        .clk(clk), .sys_rst(sys_rst), .nvm_load(nvm_load), .nvm_revision(nvm_revision),
        .nvm_reg1_ctrl(nvm_reg1_ctrl), .nvm_reg1_conf(nvm_reg1_conf),
        .nvm_reg2_ctrl(nvm_reg2_ctrl), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .bus_rvalid(bus_rvalid), .nvm_revision_field(nvm_revision_field),
        .reg1_residual_check_en(r1_rv), .reg1_pulldown_en(r1_pd), .reg1_monitor_en(r1_mon),
        .reg1_voltage_select(r1_vs), .reg1_force_multiphase(r1_mp), .reg1_force_pwm(r1_fp),
        .reg1_enable(r1_en), .reg1_current_limit(reg1_current_limit),
        .reg1_slew_select(reg1_slew_select), .reg2_residual_check_en(r2_rv),
        .reg2_pulldown_en(r2_pd), .reg2_monitor_en(r2_mon), .reg2_voltage_select(r2_vs),
        .reg2_force_pwm(r2_fp), .reg2_enable(r2_en)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        bus_addr  <= addr;
        bus_wdata <= data;
        bus_wr    <= 1'b1;
        @(posedge clk);
        bus_wr    <= 1'b0;
        #1;
    endtask

    // Checks the one-cycle valid pulse together with the returned byte.
    task automatic bus_read(input logic [7:0] addr, input logic [7:0] exp, input string what);
        @(posedge clk);
        bus_addr <= addr;
        bus_rd   <= 1'b1;
        @(posedge clk);
        bus_rd   <= 1'b0;
        #1;
        check("rvalid high", {7'h00, bus_rvalid}, 8'h01);
        check(what, bus_rdata, exp);
        @(posedge clk);
        #1;
        check("rvalid low", {7'h00, bus_rvalid}, 8'h00);
    endtask

    task automatic test_reset;
        check("ctrl1 reset", ctrl1, 8'h22);
        check("ctrl2 reset", ctrl2, 8'h22);
        check("conf1 reset", conf1, 8'h22);
        bus_read(regbank_pkg::OFS_REG1_CTRL, 8'h22, "read ctrl1");
        bus_read(regbank_pkg::OFS_REG1_CONF, 8'h22, "read conf1");
        bus_read(regbank_pkg::OFS_REG2_CTRL, 8'h22, "read ctrl2");
        $display("test_reset done");
    endtask

    // Every NVM control and settings byte has its reserved bits set; the settings byte also has the top limit code.
    task automatic test_nvm_load;
        @(posedge clk);
        nvm_revision  <= 8'hA5;
        nvm_reg1_ctrl <= 8'hFF;
        nvm_reg1_conf <= 8'hFF;
        nvm_reg2_ctrl <= 8'hFF;
        nvm_load      <= 1'b1;
        @(posedge clk);
        nvm_load      <= 1'b0;
        #1;
        check("revision", nvm_revision_field, 8'hA5);
        check("ctrl1 nvm", ctrl1, 8'hBF);
        check("ctrl2 nvm", ctrl2, 8'hBB);
        check("conf1 nvm", conf1, {2'b00, MAX_LIM, 3'h7});
        bus_read(regbank_pkg::OFS_REVISION, 8'hA5, "read revision");
        bus_read(regbank_pkg::OFS_REG1_CTRL, 8'hBF, "read ctrl1");
        bus_read(regbank_pkg::OFS_REG2_CTRL, 8'hBB, "read ctrl2");
        $display("test_nvm_load done");
    endtask

    task automatic test_ctrl_bits;
        logic [7:0] d;
        for (int i = 0; i < 8; i++)
        begin
            d = 8'h01 << i;
            bus_write(regbank_pkg::OFS_REG1_CTRL, d);
            bus_write(regbank_pkg::OFS_REG2_CTRL, d);
            check("ctrl1 bit", ctrl1, d & 8'hBF);
            check("ctrl2 bit", ctrl2, d & 8'hBB);
            bus_read(regbank_pkg::OFS_REG1_CTRL, d & 8'hBF, "read ctrl1 bit");
            bus_read(regbank_pkg::OFS_REG2_CTRL, d & 8'hBB, "read ctrl2 bit");
        end
        $display("test_ctrl_bits done");
    endtask

    // Limit and slew codes swept while regulator one stays enabled.
    task automatic test_settings;
        logic [2:0] lim;
        logic [7:0] exp;
        lim = MAX_LIM;
        bus_write(regbank_pkg::OFS_REG1_CTRL, 8'h01);
        for (int c = 0; c < 8; c++)
        begin
            if (c >= 2 && c != 5)
                lim = (3'(c) > MAX_LIM) ? MAX_LIM : 3'(c);
            exp = {2'b00, lim, 3'(c)};
            bus_write(regbank_pkg::OFS_REG1_CONF, {2'b11, 3'(c), 3'(c)});
            check("conf1 code", conf1, exp);
            check("ctrl1 kept", ctrl1, 8'h01);
            bus_read(regbank_pkg::OFS_REG1_CONF, exp, "read conf1");
        end
        $display("test_settings done");
    endtask

    task automatic test_refused;
        bus_write(regbank_pkg::OFS_REVISION, 8'h5A);
        check("revision kept", nvm_revision_field, 8'hA5);
        bus_read(regbank_pkg::OFS_REVISION, 8'hA5, "read revision");
        bus_write(8'h07, 8'hFF);
        bus_read(8'h07, regbank_pkg::UNMAPPED_DATA, "read unmapped");
        bus_read(regbank_pkg::OFS_REG1_CTRL, 8'h01, "ctrl1 after unmapped");
        $display("test_refused done");
    endtask

    // A load beats a write in the same cycle; a reserved NVM limit falls back to 4.5 A.
    task automatic test_nvm_priority;
        @(posedge clk);
        nvm_reg1_ctrl <= 8'h21;
        nvm_reg1_conf <= 8'h2C;
        nvm_reg2_ctrl <= 8'h80;
        bus_addr      <= regbank_pkg::OFS_REG1_CTRL;
        bus_wdata     <= 8'h10;
        bus_wr        <= 1'b1;
        nvm_load      <= 1'b1;
        @(posedge clk);
        bus_wr        <= 1'b0;
        nvm_load      <= 1'b0;
        #1;
        check("ctrl1 load wins", ctrl1, 8'h21);
        check("ctrl2 load", ctrl2, 8'h80);
        check("conf1 nvm gap", conf1, 8'h24);
        check("revision reload", nvm_revision_field, 8'hA5);
        $display("test_nvm_priority done");
    endtask

    // Read and write in one cycle: the read returns the old byte.
    task automatic test_read_write;
        @(posedge clk);
        bus_addr  <= regbank_pkg::OFS_REG2_CTRL;
        bus_wdata <= 8'h99;
        bus_wr    <= 1'b1;
        bus_rd    <= 1'b1;
        @(posedge clk);
        bus_wr    <= 1'b0;
        bus_rd    <= 1'b0;
        #1;
        check("old byte", bus_rdata, 8'h80);
        check("ctrl2 new", ctrl2, 8'h99);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        check("ctrl2 rereset", ctrl2, 8'h22);
        check("conf1 rereset", conf1, 8'h22);
        check("revision rereset", nvm_revision_field, regbank_pkg::RST_REVISION);
        check("rvalid rereset", {7'h00, bus_rvalid}, 8'h00);
        bus_read(regbank_pkg::OFS_REVISION, regbank_pkg::RST_REVISION, "read rereset");
        $display("test_read_write done");
    endtask

    task automatic end_sim;
        $display("Counts: comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge clk);
        bad_count++;
        end_sim();
    end

    initial
    begin
        bad_count = 0;
        comparisons = 0;
        sys_rst = 1'b1;
        nvm_load = 1'b0;
        nvm_revision = 8'h00;
        nvm_reg1_ctrl = 8'h00;
        nvm_reg1_conf = 8'h00;
        nvm_reg2_ctrl = 8'h00;
        bus_addr = 8'h00;
        bus_wr = 1'b0;
        bus_wdata = 8'h00;
        bus_rd = 1'b0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        test_reset();
        test_nvm_load();
        test_ctrl_bits();
        test_settings();
        test_refused();
        test_nvm_priority();
        test_read_write();
        end_sim();
    end
endmodule
